// ==== bev_pkg.sv ====
// Constants and carrier types for the bridge error log and VC capability bank.
// Assumes a 40 MHz core clock and dword-aligned extended configuration accesses.
package bev_pkg;

   // Extended configuration byte offsets
   localparam logic [11:0] OFS_LOG_W0 = 12'h13c;
   localparam logic [11:0] OFS_LOG_W1 = 12'h140;
   localparam logic [11:0] OFS_LOG_W2 = 12'h144;
   localparam logic [11:0] OFS_LOG_W3 = 12'h148;
   localparam logic [11:0] OFS_VC_ID = 12'h150;
   localparam logic [11:0] OFS_NEXT_VER = 12'h152;
   localparam logic [11:0] OFS_PVC_ONE = 12'h154;

   // Fixed field values
   localparam logic [15:0] VC_ID_VAL = 16'h0002;
   localparam logic [11:0] NEXT_PTR_VAL = 12'h000;
   localparam logic [3:0] CAP_VER_VAL = 4'h1;
   localparam logic [1:0] TABLE_SIZE_VAL = 2'h2;
   localparam logic [1:0] REF_CLK_VAL = 2'h0;
   localparam logic [2:0] LOW_PRIO_NORMAL = 3'h1;
   localparam logic [2:0] LOW_PRIO_STRICT = 3'h0;
   localparam logic [2:0] EXTENDED_CHANNEL_COUNT_VAL = 3'h1;

   // Field positions in the 128-bit log
   localparam int LOG_LOWER_CMD_LSB = 36;
   localparam int LOG_UPPER_CMD_LSB = 40;
   localparam int LOG_ADDR_LO_LSB = 64;
   localparam int LOG_ADDR_HI_LSB = 96;
   localparam logic [127:0] LOG_RESET = 128'h0;

   // Arbitration time base
   localparam int ARB_TIMER_NS = 100;
   localparam int CLK_PERIOD_NS = 25;
   localparam int ARB_TICK_CYCLES = ARB_TIMER_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic dual_addr;
      logic [3:0] cmd_second;
      logic [3:0] cmd_first;
      logic [31:0] addr_second;
      logic [31:0] addr_first;
   } bev_err_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } bev_cfg_req_t;

endpackage : bev_pkg

// ==== bev_regs.sv ====
// Error header log and VC capability registers of the bridge, with the
// upstream VC arbiter that the strict priority enable steers.
// Assumes configuration requests, error events and arbiter requests come from
// logic on ref_clk_i; the link and global reset pins are asynchronous.
module bev_regs
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic link_reset_n_i,
   input wire logic global_reset_input_n_i,
   input wire bev_pkg::bev_cfg_req_t cfg_req_i,
   input wire logic err_log_i,
   input wire bev_pkg::bev_err_t err_i,
   input wire logic strict_prio_en_i,
   input wire logic vc0_req_i,
   input wire logic ext_vc_req_i,
   output logic cfg_ack_o,
   output logic [31:0] cfg_rdata_o,
   output logic vc0_gnt_o,
   output logic ext_vc_gnt_o,
   output logic arb_tick_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Dword match of a byte offset; both 16-bit registers share the 150h dword
   function automatic logic dword_hit(input logic [11:0] addr, input logic [11:0] ofs);
      dword_hit = (addr[11:2] == ofs[11:2]);
   endfunction : dword_hit

   ////////////////////////////////////////////////////////////////////////////////
   // Reset synchronisers
   logic rst_meta_reg;
   logic rst_n;
   logic [1:0] link_sync_reg;
   logic [1:0] glob_sync_reg;
   logic log_clear;

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_sync_reg <= 2'h3;
         glob_sync_reg <= 2'h3;
      end
      else
      begin
         link_sync_reg <= {link_sync_reg[0], link_reset_n_i};
         glob_sync_reg <= {glob_sync_reg[0], global_reset_input_n_i};
      end
   end

   assign log_clear = !link_sync_reg[1] || !glob_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Secondary error header log
   logic [127:0] log_reg;
   logic [127:0] log_next;

   always_comb
   begin
      log_next = bev_pkg::LOG_RESET;
      log_next[bev_pkg::LOG_ADDR_LO_LSB +: 32] = err_i.addr_first;
      log_next[bev_pkg::LOG_ADDR_HI_LSB +: 32] = err_i.dual_addr ? err_i.addr_second : 32'h0;
      log_next[bev_pkg::LOG_UPPER_CMD_LSB +: 4] = err_i.dual_addr ? err_i.cmd_second : 4'h0;
      log_next[bev_pkg::LOG_LOWER_CMD_LSB +: 4] = err_i.cmd_first;
   end

   // Reset wins over a capture in the same cycle: the log must come up clean
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         log_reg <= bev_pkg::LOG_RESET;
      else if (log_clear)
         log_reg <= bev_pkg::LOG_RESET;
      else if (err_log_i)
         log_reg <= log_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux
   logic [31:0] pvc_one;
   logic [31:0] rd_value;

   always_comb
   begin
      pvc_one = 32'h0;
      pvc_one[11:10] = bev_pkg::TABLE_SIZE_VAL;
      pvc_one[9:8] = bev_pkg::REF_CLK_VAL;
      pvc_one[6:4] = strict_prio_en_i ? bev_pkg::LOW_PRIO_STRICT : bev_pkg::LOW_PRIO_NORMAL;
      pvc_one[2:0] = bev_pkg::EXTENDED_CHANNEL_COUNT_VAL;
   end

   always_comb
   begin
      rd_value = 32'h0;
      if (dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W0))
         rd_value = log_reg[31:0];
      else if (dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W1))
         rd_value = log_reg[63:32];
      else if (dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W2))
         rd_value = log_reg[95:64];
      else if (dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W3))
         rd_value = log_reg[127:96];
      else if (dword_hit(cfg_req_i.addr, bev_pkg::OFS_VC_ID))
         rd_value = {bev_pkg::NEXT_PTR_VAL, bev_pkg::CAP_VER_VAL, bev_pkg::VC_ID_VAL};
      else if (dword_hit(cfg_req_i.addr, bev_pkg::OFS_PVC_ONE))
         rd_value = pvc_one;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_ack_o <= 1'b0;
         cfg_rdata_o <= 32'h0;
      end
      else
      begin
         cfg_ack_o <= cfg_req_i.rd || cfg_req_i.wr;
         cfg_rdata_o <= cfg_req_i.rd ? rd_value : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Upstream VC arbiter and its 100 ns pacing tick
   localparam int TICK_W = $clog2(bev_pkg::ARB_TICK_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(bev_pkg::ARB_TICK_CYCLES - 1);
   logic [TICK_W-1:0] tick_cnt_reg;
   logic last_ext_reg;

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_reg <= '0;
         arb_tick_o <= 1'b0;
      end
      else
      begin
         tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 : tick_cnt_reg + TICK_W'(1);
         arb_tick_o <= (tick_cnt_reg == TICK_LAST);
      end
   end

   // Round-robin turns change only on a tick, so one VC holds a 100 ns slot
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vc0_gnt_o <= 1'b0;
         ext_vc_gnt_o <= 1'b0;
         last_ext_reg <= 1'b0;
      end
      else if (strict_prio_en_i)
      begin
         ext_vc_gnt_o <= ext_vc_req_i;
         vc0_gnt_o <= vc0_req_i && !ext_vc_req_i;
      end
      else
      begin
         if (ext_vc_req_i && (!vc0_req_i || !last_ext_reg))
         begin
            ext_vc_gnt_o <= 1'b1;
            vc0_gnt_o <= 1'b0;
         end
         else
         begin
            ext_vc_gnt_o <= 1'b0;
            vc0_gnt_o <= vc0_req_i;
         end
         if (arb_tick_o && ext_vc_req_i && vc0_req_i)
            last_ext_reg <= !last_ext_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   // Counter wraps before its compare value below two cycles
   if (bev_pkg::ARB_TICK_CYCLES < 2)
   begin : g_tick_too_short
      $error("Arbitration tick needs at least two cycles");
   end
   // A clock that does not divide the timer would drift the slot length
   if (bev_pkg::ARB_TICK_CYCLES * bev_pkg::CLK_PERIOD_NS != bev_pkg::ARB_TIMER_NS)
   begin : g_tick_inexact
      $error("Clock period does not divide the arbitration timer");
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n);

   logic rd_w0;
   logic rd_w1;
   logic rd_w2;
   logic rd_w3;
   logic rd_id;
   logic rd_pvc;
   assign rd_w0 = cfg_req_i.rd && dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W0);
   assign rd_w1 = cfg_req_i.rd && dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W1);
   assign rd_w2 = cfg_req_i.rd && dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W2);
   assign rd_w3 = cfg_req_i.rd && dword_hit(cfg_req_i.addr, bev_pkg::OFS_LOG_W3);
   assign rd_id = cfg_req_i.rd && dword_hit(cfg_req_i.addr, bev_pkg::OFS_VC_ID);
   assign rd_pvc = cfg_req_i.rd && dword_hit(cfg_req_i.addr, bev_pkg::OFS_PVC_ONE);

   // Word two read straight after a capture has settled
   chk_log_first_addr: assert property (
      err_log_i && !log_clear ##1 !err_log_i && !log_clear ##1 rd_w2 |=>
         cfg_rdata_o == $past(err_i.addr_first, 3))
      else $error("First address phase not in log word two");

   chk_log_single_zero: assert property (
      err_log_i && !log_clear && !err_i.dual_addr |=> log_reg[127:96] == 32'h0)
      else $error("Single address cycle left upper address nonzero");

   chk_log_dual_addr: assert property (
      err_log_i && !log_clear && err_i.dual_addr |=> log_reg[127:96] == $past(err_i.addr_second))
      else $error("Second address phase not logged");

   chk_upper_cmd: assert property (
      err_log_i && !log_clear && err_i.dual_addr |=> log_reg[43:40] == $past(err_i.cmd_second))
      else $error("Second phase command not logged");

   chk_lower_cmd: assert property (
      err_log_i && !log_clear |=> log_reg[39:36] == $past(err_i.cmd_first))
      else $error("First phase command not logged");

   chk_reserved_log: assert property (
      rd_w0 || rd_w1 |=> cfg_ack_o && cfg_rdata_o[31:12] == 20'h0 &&
         cfg_rdata_o[3:0] == 4'h0 && ($past(rd_w1) || cfg_rdata_o[11:4] == 8'h0))
      else $error("Reserved log bits read nonzero");

   chk_log_clear: assert property (
      log_clear |=> log_reg == bev_pkg::LOG_RESET)
      else $error("Log not cleared by reset source");

   chk_clear_read: assert property (
      log_clear ##1 rd_w3 |=> cfg_rdata_o == 32'h0)
      else $error("Upper log word read nonzero during reset clear");

   chk_cap_header: assert property (
      rd_id |=> cfg_ack_o && cfg_rdata_o == 32'h0001_0002)
      else $error("Capability header value wrong");

   chk_next_version: assert property (
      rd_id |=> cfg_rdata_o[31:20] == 12'h000 && cfg_rdata_o[19:16] == 4'h1)
      else $error("Next pointer or version wrong");

   chk_pvc_fixed: assert property (
      rd_pvc |=> cfg_rdata_o[31:7] == 25'h10 && cfg_rdata_o[3:0] == 4'h1)
      else $error("Port VC capability fixed fields wrong");

   chk_low_prio: assert property (
      rd_pvc |=> cfg_rdata_o[6:4] == ($past(strict_prio_en_i) ? 3'h0 : 3'h1))
      else $error("Low priority count disagrees with strict enable");

   chk_strict_win: assert property (
      strict_prio_en_i && ext_vc_req_i |=> ext_vc_gnt_o && !vc0_gnt_o)
      else $error("Extended VC lost under strict priority");

   chk_strict_vc0: assert property (
      strict_prio_en_i && vc0_req_i && !ext_vc_req_i |=> vc0_gnt_o && !ext_vc_gnt_o)
      else $error("VC0 not granted while alone under strict priority");

   chk_grant_onehot: assert property (
      !(vc0_gnt_o && ext_vc_gnt_o))
      else $error("Both virtual channels granted at once");

   chk_turn_on_tick: assert property (
      $changed(last_ext_reg) |-> $past(arb_tick_o))
      else $error("Round-robin turn changed off the 100 ns tick");

   chk_idle_rdata: assert property (
      !cfg_req_i.rd |=> cfg_rdata_o == 32'h0)
      else $error("Read data present without a read");

   chk_tick_period: assert property (
      arb_tick_o |=> !arb_tick_o [*3] ##1 arb_tick_o)
      else $error("Arbitration tick not every 100 ns");

   chk_write_ignored: assert property (
      cfg_req_i.wr && !err_log_i && !log_clear |=> $stable(log_reg) && cfg_ack_o &&
         cfg_rdata_o == 32'h0)
      else $error("Configuration write disturbed the bank");

   cov_dual_capture: cover property (err_log_i && err_i.dual_addr ##1 rd_w3);
   cov_strict_read: cover property (strict_prio_en_i && rd_pvc);
   cov_clear_after_log: cover property (err_log_i ##[1:8] log_clear);
   cov_rr_swap: cover property (!strict_prio_en_i && ext_vc_gnt_o ##[1:8] vc0_gnt_o);
   cov_clear_read: cover property (log_clear ##1 rd_w3);

endmodule : bev_regs

// ==== bev_host_model.sv ====
// Upstream host model that issues configuration reads and writes.
// Assumes the bank acks exactly one cycle after the edge that takes a request.
module bev_host_model
(
   input wire logic ref_clk_i,
   input wire logic cfg_ack_i,
   input wire logic [31:0] cfg_rdata_i,
   output bev_pkg::bev_cfg_req_t cfg_req_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial cfg_req_o = '0;

   // Released address is inverted so a stale value never passes as valid
   task automatic access(input logic wr, input logic [11:0] addr, output logic ack,
                         output logic [31:0] data);
      @(posedge ref_clk_i);
      cfg_req_o.rd <= !wr;
      cfg_req_o.wr <= wr;
      cfg_req_o.addr <= addr;
      cfg_req_o.wdata <= 32'hffff_ffff;
      @(posedge ref_clk_i);
      cfg_req_o <= {2'h0, ~addr, 32'h0};
      @(posedge ref_clk_i);
      ack = cfg_ack_i;
      data = cfg_rdata_i;
   endtask : access
endmodule : bev_host_model

// ==== bev_regs_tb_top.sv ====
// Self-checking bench for the error log and VC capability bank.
// Assumes the host model drives the configuration port; other inputs come from here.
module bev_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rstn, link_n, glob_n, err_log, strict, vc0_req, ext_req;
   logic ack, vc0_gnt, ext_gnt, tick;
   logic [31:0] rdata;
   bev_pkg::bev_err_t err;
   bev_pkg::bev_cfg_req_t req;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int ticks, both, v, x;

   bev_regs u_bev_regs (.ref_clk_i(clk), .rstn_i(rstn), .link_reset_n_i(link_n),
      .global_reset_input_n_i(glob_n), .cfg_req_i(req), .err_log_i(err_log), .err_i(err),
      .strict_prio_en_i(strict), .vc0_req_i(vc0_req), .ext_vc_req_i(ext_req),
      .cfg_ack_o(ack), .cfg_rdata_o(rdata), .vc0_gnt_o(vc0_gnt), .ext_vc_gnt_o(ext_gnt),
      .arb_tick_o(tick));
   bev_host_model u_bev_host_model (.ref_clk_i(clk), .cfg_ack_i(ack), .cfg_rdata_i(rdata),
      .cfg_req_o(req));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // Ceiling well above the roughly 213 cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         give_verdict();
      end
   end

   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : chk

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic k;
      logic [31:0] d;
      u_bev_host_model.access(1'b0, a, k, d);
      chk(k === 1'b1 && d === exp, $sformatf("read %h gave %h", a, d));
   endtask : rd_chk

   task automatic wr_chk(input logic [11:0] a);
      logic k;
      logic [31:0] d;
      u_bev_host_model.access(1'b1, a, k, d);
      chk(k === 1'b1 && d === 32'h0, "write ack");
   endtask : wr_chk

   task automatic capture(input bev_pkg::bev_err_t e);
      @(posedge clk);
      err_log <= 1'b1;
      err <= e;
      @(posedge clk);
      err_log <= 1'b0;
      err <= ~e;
   endtask : capture

   task automatic log_chk(input logic [31:0] w3, input logic [31:0] w2, input logic [31:0] w1);
      rd_chk(12'h144, w2);
      rd_chk(12'h13c, 32'h0);
      rd_chk(12'h140, w1);
      rd_chk(12'h148, w3);
   endtask : log_chk

   initial
   begin
      {rstn, err_log, strict, vc0_req, ext_req} = '0;
      {link_n, glob_n} = 2'h3;
      err = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      log_chk(32'h0, 32'h0, 32'h0);
      rd_chk(12'h150, 32'h0001_0002);
      rd_chk(12'h152, 32'h0001_0002);
      rd_chk(12'h154, 32'h0000_0811);
      @(posedge clk);
      strict <= 1'b1;
      rd_chk(12'h154, 32'h0000_0801);
      rd_chk(12'h100, 32'h0);
      $display("test fixed values done");
      wr_chk(12'h150);
      wr_chk(12'h154);
      wr_chk(12'h13c);
      rd_chk(12'h150, 32'h0001_0002);
      rd_chk(12'h154, 32'h0000_0801);
      $display("test writes done");
      capture({1'b1, 4'ha, 4'h5, 32'h8765_4321, 32'h1234_5678});
      log_chk(32'h8765_4321, 32'h1234_5678, 32'h0000_0a50);
      capture({1'b1, 4'h3, 4'h9, 32'h1111_2222, 32'h3333_4444});
      capture({1'b0, 4'hf, 4'h6, 32'hdead_beef, 32'h0bad_cafe});
      log_chk(32'h0, 32'h0bad_cafe, 32'h0000_0060);
      $display("test capture done");
      for (int k = 0; k < 3; k++)
      begin
         capture({1'b1, 4'hc, 4'h7, 32'hffff_ffff, 32'hffff_ffff});
         @(posedge clk);
         {link_n, glob_n, rstn} <= ~(3'h4 >> k);
         repeat (3) @(posedge clk);
         if (k < 2)
            rd_chk(12'h148, 32'h0);
         else
            repeat (3) @(posedge clk);
         {link_n, glob_n, rstn} <= 3'h7;
         repeat (4) @(posedge clk);
         log_chk(32'h0, 32'h0, 32'h0);
      end
      $display("test log resets done");
      @(posedge clk);
      {strict, vc0_req, ext_req} <= 3'h7;
      repeat (2) @(posedge clk);
      repeat (8)
      begin
         @(posedge clk);
         #1;
         chk(ext_gnt === 1'b1 && vc0_gnt === 1'b0, "strict grant");
      end
      @(posedge clk);
      ext_req <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(vc0_gnt === 1'b1 && ext_gnt === 1'b0, "vc0 alone");
      @(posedge clk);
      {strict, ext_req} <= 2'h1;
      repeat (2) @(posedge clk);
      {ticks, both, v, x} = '0;
      repeat (40)
      begin
         @(posedge clk);
         #1;
         ticks += int'(tick === 1'b1);
         both += int'(vc0_gnt === 1'b1 && ext_gnt === 1'b1);
         v += int'(vc0_gnt === 1'b1);
         x += int'(ext_gnt === 1'b1);
      end
      chk(ticks == 40 / bev_pkg::ARB_TICK_CYCLES, "tick rate");
      chk(both == 0 && v > 0 && x > 0, "round robin");
      $display("test arbiter done");
      give_verdict();
   end
endmodule : bev_regs_tb_top
